// ===== include/pll_control_params.svh
// Offsets, field positions, keys and decode figures of the PLL control block
`ifndef PLL_CONTROL_PARAMS_SVH
`define PLL_CONTROL_PARAMS_SVH

`define ADDR_PLL_CONTROL   4'h0
`define ADDR_UNLOCK_KEY    4'h4
`define ADDR_STATUS        4'h8
`define ADDR_LSB           2
`define ADDR_MSB           3

`define ODIV_MSB           26
`define ODIV_LSB           24
`define MULT_MSB           22
`define MULT_LSB           16
`define IDIV_MSB           10
`define IDIV_LSB           8
`define ICLK_BIT           7
`define RANGE_MSB          2
`define RANGE_LSB          0
`define PLL_WRITABLE_MASK  32'h077f_0787

`define ODIV_CODE_MIN      3'h1
`define ODIV_CODE_MAX      3'h5
`define RATIO_BASE         6'h01
`define MULT_OFFSET        8'h01
`define CURRENT_OSCILLATOR_CODE_LOOP_ACTIVE   3'h1

`define UNLOCK_KEY_FIRST   32'h5a5a_0f0f
`define UNLOCK_KEY_SECOND  32'ha5a5_f0f0

`define STAT_UNLOCKED_BIT  0
`define STAT_ACTIVE_BIT    1
`define STAT_REFUSED_BIT   2

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== include/pll_control_pkg.sv
// Types shared by the PLL control block
package pll_control_pkg;
  typedef enum logic [1:0] {
    LOCKED,
    FIRST_KEY_SEEN,
    UNLOCKED
  } unlock_type;
endpackage

// ===== design/system_pll_control.sv
// System PLL control register with unlock guard, behind an AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
`include "pll_control_params.svh"

module system_pll_control
  import pll_control_pkg::*;
(
  // Clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RST_N,
  // AXI4-Lite write address and data
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  input  wire logic [31:0] I_AWADDR,
  input  wire logic [2:0]  I_AWPROT,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  // AXI4-Lite write response
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  output logic [1:0]       O_BRESP,
  // AXI4-Lite read
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  input  wire logic [31:0] I_ARADDR,
  input  wire logic [2:0]  I_ARPROT,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  // Configuration word defaults
  input  wire logic [2:0]  I_CFG_OUTPUT_DIVIDER_DEFAULT,
  input  wire logic [6:0]  I_CFG_MULTIPLIER_DEFAULT,
  input  wire logic [2:0]  I_CFG_INPUT_DIVIDER_DEFAULT,
  input  wire logic        I_CFG_INPUT_CLOCK_SELECT_DEFAULT,
  input  wire logic [2:0]  I_CFG_INPUT_RANGE_DEFAULT,
  // Oscillator selector
  input  wire logic [2:0]  I_CURRENT_OSCILLATOR_CODE,
  // PLL settings
  output logic [2:0]       O_OUTPUT_DIVIDER_FIELD,
  output logic [6:0]       O_MULTIPLIER_FIELD,
  output logic [2:0]       O_INPUT_DIVIDER_FIELD,
  output logic             O_INPUT_CLOCK_SELECT,
  output logic [2:0]       O_INPUT_RANGE_FIELD,
  output logic [5:0]       O_OUTPUT_DIVIDE_RATIO,
  output logic             O_OUTPUT_DIVIDER_LEGAL,
  output logic [7:0]       O_MULTIPLY_FACTOR
);

  // Bus state
  logic        aw_full;
  logic        w_full;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        next_aw_full;
  logic        next_w_full;
  logic [3:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  // Register state
  logic [31:0] pll_control_register;
  logic [31:0] next_pll_control_register;
  unlock_type  unlock;
  unlock_type  next_unlock;
  logic        refused;
  logic        next_refused;
  logic [5:0]  ratio;
  logic [5:0]  next_ratio;
  logic        ratio_legal;
  logic        next_ratio_legal;
  logic [7:0]  factor;
  logic [7:0]  next_factor;

  logic        do_write;
  logic        loop_active;
  logic        pll_accept;
  logic [31:0] strobe_mask;
  logic [31:0] status_word;
  logic [31:0] cfg_word;

  assign O_AWREADY = !aw_full && !bvalid;
  assign O_WREADY  = !w_full && !bvalid;
  assign O_ARREADY = !rvalid;
  assign do_write  = aw_full && w_full && !bvalid;
  assign loop_active = (I_CURRENT_OSCILLATOR_CODE == `CURRENT_OSCILLATOR_CODE_LOOP_ACTIVE);
  // A write lands only after the full key pair and never while the loop clocks the core
  assign pll_accept = do_write && (aw_addr == `ADDR_PLL_CONTROL) && (unlock == UNLOCKED)
                      && !loop_active;

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++) begin : g_strobe
      assign strobe_mask[lane*8 +: 8] = {8{w_strb[lane]}};
    end
  endgenerate

  always_comb begin
    cfg_word = 32'h0000_0000;
    cfg_word[`ODIV_MSB:`ODIV_LSB]   = I_CFG_OUTPUT_DIVIDER_DEFAULT;
    cfg_word[`MULT_MSB:`MULT_LSB]   = I_CFG_MULTIPLIER_DEFAULT;
    cfg_word[`IDIV_MSB:`IDIV_LSB]   = I_CFG_INPUT_DIVIDER_DEFAULT;
    cfg_word[`ICLK_BIT]             = I_CFG_INPUT_CLOCK_SELECT_DEFAULT;
    cfg_word[`RANGE_MSB:`RANGE_LSB] = I_CFG_INPUT_RANGE_DEFAULT;
  end

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`STAT_UNLOCKED_BIT] = (unlock == UNLOCKED);
    status_word[`STAT_ACTIVE_BIT]   = loop_active;
    status_word[`STAT_REFUSED_BIT]  = refused;
  end

  // Bus channels
  always_comb begin
    next_aw_full = aw_full;
    next_w_full  = w_full;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (I_AWVALID && O_AWREADY) begin
      next_aw_full = 1'b1;
      next_aw_addr = I_AWADDR[3:0];
    end
    if (I_WVALID && O_WREADY) begin
      next_w_full = 1'b1;
      next_w_data = I_WDATA;
      next_w_strb = I_WSTRB;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      unique case (aw_addr)
        `ADDR_PLL_CONTROL, `ADDR_UNLOCK_KEY, `ADDR_STATUS: next_bresp = `RESP_OKAY;
        default: next_bresp = `RESP_SLVERR;
      endcase
    end
    if (bvalid && I_BREADY) begin
      next_bvalid = 1'b0;
    end
    if (rvalid && I_RREADY) begin
      next_rvalid = 1'b0;
    end
    if (I_ARVALID && O_ARREADY) begin
      next_rvalid = 1'b1;
      next_rresp  = `RESP_OKAY;
      unique case (I_ARADDR[3:0])
        `ADDR_PLL_CONTROL: next_rdata = pll_control_register & `PLL_WRITABLE_MASK;
        `ADDR_UNLOCK_KEY:  next_rdata = 32'h0000_0000;
        `ADDR_STATUS:      next_rdata = status_word;
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = `RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // Control register, unlock sequencer and decoded settings
  always_comb begin
    next_pll_control_register = pll_control_register;
    next_unlock  = unlock;
    next_refused = refused;
    if (do_write) begin
      // Any bus write other than the expected key breaks the sequence
      next_unlock = LOCKED;
      if (aw_addr == `ADDR_UNLOCK_KEY && (&w_strb)) begin
        if (w_data == `UNLOCK_KEY_FIRST) begin
          next_unlock = FIRST_KEY_SEEN;
        end else if (w_data == `UNLOCK_KEY_SECOND && unlock == FIRST_KEY_SEEN) begin
          next_unlock = UNLOCKED;
        end
      end
      if (aw_addr == `ADDR_STATUS && w_strb[0] && w_data[`STAT_REFUSED_BIT]) begin
        next_refused = 1'b0;
      end
      if (aw_addr == `ADDR_PLL_CONTROL && !pll_accept) begin
        next_refused = 1'b1;
      end
    end
    if (pll_accept) begin
      next_pll_control_register = (pll_control_register & ~(strobe_mask & `PLL_WRITABLE_MASK))
                                  | (w_data & strobe_mask & `PLL_WRITABLE_MASK);
    end
    next_factor = {1'b0, next_pll_control_register[`MULT_MSB:`MULT_LSB]} + `MULT_OFFSET;
    next_ratio_legal = (next_pll_control_register[`ODIV_MSB:`ODIV_LSB] >= `ODIV_CODE_MIN)
                       && (next_pll_control_register[`ODIV_MSB:`ODIV_LSB] <= `ODIV_CODE_MAX);
    // Reserved codes report ratio zero so nothing downstream trusts them
    next_ratio = next_ratio_legal ? (`RATIO_BASE << next_pll_control_register[`ODIV_MSB:`ODIV_LSB])
                                  : 6'h00;
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      pll_control_register <= cfg_word;
      unlock      <= LOCKED;
      refused     <= 1'b0;
      ratio       <= 6'h00;
      ratio_legal <= 1'b0;
      factor      <= 8'h00;
    end else begin
      pll_control_register <= next_pll_control_register;
      unlock      <= next_unlock;
      refused     <= next_refused;
      ratio       <= next_ratio;
      ratio_legal <= next_ratio_legal;
      factor      <= next_factor;
    end
  end

  assign O_BVALID = bvalid;
  assign O_BRESP  = bresp;
  assign O_RVALID = rvalid;
  assign O_RDATA  = rdata;
  assign O_RRESP  = rresp;
  assign O_OUTPUT_DIVIDER_FIELD = pll_control_register[`ODIV_MSB:`ODIV_LSB];
  assign O_MULTIPLIER_FIELD     = pll_control_register[`MULT_MSB:`MULT_LSB];
  assign O_INPUT_DIVIDER_FIELD  = pll_control_register[`IDIV_MSB:`IDIV_LSB];
  assign O_INPUT_CLOCK_SELECT   = pll_control_register[`ICLK_BIT];
  assign O_INPUT_RANGE_FIELD    = pll_control_register[`RANGE_MSB:`RANGE_LSB];
  assign O_OUTPUT_DIVIDE_RATIO  = ratio;
  assign O_OUTPUT_DIVIDER_LEGAL = ratio_legal;
  assign O_MULTIPLY_FACTOR      = factor;

  // Helper for the read-back check
  logic rd_is_pll;
  always_ff @(posedge I_CORE_CLK) begin
    if (!I_RST_N) begin
      rd_is_pll <= 1'b0;
    end else if (I_ARVALID && O_ARREADY) begin
      rd_is_pll <= (I_ARADDR[3:0] == `ADDR_PLL_CONTROL);
    end
  end

  chk_odiv_ratio_decode: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    $past(I_RST_N) |-> (ratio_legal ? (ratio == (`RATIO_BASE << O_OUTPUT_DIVIDER_FIELD)) : (ratio == 6'h00))
      && (ratio_legal == (O_OUTPUT_DIVIDER_FIELD inside {[`ODIV_CODE_MIN:`ODIV_CODE_MAX]})))
    else $error("output divide ratio does not match the divider code");

  chk_mult_factor_value: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    $past(I_RST_N) |-> (factor == {1'b0, O_MULTIPLIER_FIELD} + `MULT_OFFSET))
    else $error("multiply factor is not the field plus one");

  chk_reset_cfg_load: assert property (@(posedge I_CORE_CLK)
    !I_RST_N |=> (O_OUTPUT_DIVIDER_FIELD == $past(I_CFG_OUTPUT_DIVIDER_DEFAULT))
      && (O_MULTIPLIER_FIELD == $past(I_CFG_MULTIPLIER_DEFAULT))
      && (O_INPUT_DIVIDER_FIELD == $past(I_CFG_INPUT_DIVIDER_DEFAULT))
      && (O_INPUT_CLOCK_SELECT == $past(I_CFG_INPUT_CLOCK_SELECT_DEFAULT))
      && (O_INPUT_RANGE_FIELD == $past(I_CFG_INPUT_RANGE_DEFAULT)))
    else $error("fields not loaded from configuration at reset");

  chk_locked_write_ignored: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (do_write && aw_addr == `ADDR_PLL_CONTROL && unlock != UNLOCKED) |=> $stable(pll_control_register) ##1 refused)
    else $error("control register changed without unlock");

  chk_active_loop_block: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (do_write && aw_addr == `ADDR_PLL_CONTROL && I_CURRENT_OSCILLATOR_CODE == `CURRENT_OSCILLATOR_CODE_LOOP_ACTIVE)
      |=> $stable(pll_control_register))
    else $error("control register changed while loop is the clock source");

  chk_reserved_read_zero: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (O_RVALID && rd_is_pll) |-> (O_RDATA[31:27] == 5'h00) && !O_RDATA[23] && (O_RDATA[15:11] == 5'h00))
    else $error("unimplemented bits read non-zero");

  chk_field_write_store: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (pll_accept && w_strb == 4'hf) |=> (O_INPUT_DIVIDER_FIELD == $past(w_data[`IDIV_MSB:`IDIV_LSB]))
      && (O_INPUT_CLOCK_SELECT == $past(w_data[`ICLK_BIT]))
      && (O_INPUT_RANGE_FIELD == $past(w_data[`RANGE_MSB:`RANGE_LSB]))
      && (unlock == LOCKED))
    else $error("accepted write did not store the fields");

  chk_bresp_hold: assert property (@(posedge I_CORE_CLK) disable iff (!I_RST_N)
    (O_BVALID && !I_BREADY) |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped before it was taken");

endmodule // system_pll_control
`default_nettype wire

// ===== tb/system_pll_control_bench.sv
// Self-checking bench for the PLL control register block over AXI4-Lite
`timescale 1ns/1ns
`default_nettype none
`include "pll_control_params.svh"

module system_pll_control_bench;
  logic        I_CORE_CLK, I_RST_N, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic [31:0] I_AWADDR, I_WDATA, I_ARADDR;
  logic [3:0]  I_WSTRB;
  logic [2:0]  I_CFG_OUTPUT_DIVIDER_DEFAULT, I_CFG_INPUT_DIVIDER_DEFAULT, I_CFG_INPUT_RANGE_DEFAULT;
  logic [6:0]  I_CFG_MULTIPLIER_DEFAULT;
  logic        I_CFG_INPUT_CLOCK_SELECT_DEFAULT;
  logic [2:0]  I_CURRENT_OSCILLATOR_CODE;
  wire logic        O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID, O_INPUT_CLOCK_SELECT;
  wire logic        O_OUTPUT_DIVIDER_LEGAL;
  wire logic [1:0]  O_BRESP, O_RRESP;
  wire logic [31:0] O_RDATA;
  wire logic [2:0]  O_OUTPUT_DIVIDER_FIELD, O_INPUT_DIVIDER_FIELD, O_INPUT_RANGE_FIELD;
  wire logic [6:0]  O_MULTIPLIER_FIELD;
  wire logic [5:0]  O_OUTPUT_DIVIDE_RATIO;
  wire logic [7:0]  O_MULTIPLY_FACTOR;
  int n_mismatch = 0;
  int n_tests = 0;

  system_pll_control i_system_pll_control (
    .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N),
    .I_AWVALID(I_AWVALID), .O_AWREADY(O_AWREADY), .I_AWADDR(I_AWADDR), .I_AWPROT(3'h0),
    .I_WVALID(I_WVALID), .O_WREADY(O_WREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB),
    .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_BRESP(O_BRESP),
    .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .I_ARADDR(I_ARADDR), .I_ARPROT(3'h0),
    .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA), .O_RRESP(O_RRESP),
    .I_CFG_OUTPUT_DIVIDER_DEFAULT(I_CFG_OUTPUT_DIVIDER_DEFAULT),
    .I_CFG_MULTIPLIER_DEFAULT(I_CFG_MULTIPLIER_DEFAULT),
    .I_CFG_INPUT_DIVIDER_DEFAULT(I_CFG_INPUT_DIVIDER_DEFAULT),
    .I_CFG_INPUT_CLOCK_SELECT_DEFAULT(I_CFG_INPUT_CLOCK_SELECT_DEFAULT),
    .I_CFG_INPUT_RANGE_DEFAULT(I_CFG_INPUT_RANGE_DEFAULT),
    .I_CURRENT_OSCILLATOR_CODE(I_CURRENT_OSCILLATOR_CODE),
    .O_OUTPUT_DIVIDER_FIELD(O_OUTPUT_DIVIDER_FIELD), .O_MULTIPLIER_FIELD(O_MULTIPLIER_FIELD),
    .O_INPUT_DIVIDER_FIELD(O_INPUT_DIVIDER_FIELD), .O_INPUT_CLOCK_SELECT(O_INPUT_CLOCK_SELECT),
    .O_INPUT_RANGE_FIELD(O_INPUT_RANGE_FIELD), .O_OUTPUT_DIVIDE_RATIO(O_OUTPUT_DIVIDE_RATIO),
    .O_OUTPUT_DIVIDER_LEGAL(O_OUTPUT_DIVIDER_LEGAL), .O_MULTIPLY_FACTOR(O_MULTIPLY_FACTOR)
  );

  initial begin
    I_CORE_CLK = 1'b0;
    forever #20 I_CORE_CLK = ~I_CORE_CLK;
  end

  task automatic report_and_stop();
    if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: %s response %h expected %h", $time, what, got, exp);
    end
  endtask

  // Readies are sampled at the falling edge: inputs are steady over the cycle, so this is the edge value
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    logic ka, kw, kb;
    logic [1:0] r;
    I_AWVALID <= 1'b1;
    I_AWADDR  <= 32'(a);
    I_WVALID  <= 1'b1;
    I_WDATA   <= d;
    I_WSTRB   <= s;
    do begin
      @(negedge I_CORE_CLK);
      ka = I_AWVALID && O_AWREADY;
      kw = I_WVALID && O_WREADY;
      kb = O_BVALID;
      r  = O_BRESP;
      @(posedge I_CORE_CLK);
      if (ka) I_AWVALID <= 1'b0;
      if (kw) I_WVALID <= 1'b0;
    end while (kb !== 1'b1);
    cmp_resp(r, er, "write");
  endtask

  task automatic chk_read(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ka, kr;
    logic [1:0] r;
    logic [31:0] d;
    I_ARVALID <= 1'b1;
    I_ARADDR  <= 32'(a);
    do begin
      @(negedge I_CORE_CLK);
      ka = I_ARVALID && O_ARREADY;
      kr = O_RVALID;
      r  = O_RRESP;
      d  = O_RDATA;
      @(posedge I_CORE_CLK);
      if (ka) I_ARVALID <= 1'b0;
    end while (kr !== 1'b1);
    cmp_resp(r, er, "read");
    cmp_word(d, ed, "read data");
  endtask

  task automatic unlock();
    wr(`ADDR_UNLOCK_KEY, `UNLOCK_KEY_FIRST, 4'hf, `RESP_OKAY);
    wr(`ADDR_UNLOCK_KEY, `UNLOCK_KEY_SECOND, 4'hf, `RESP_OKAY);
  endtask

  function automatic logic [31:0] pack(input logic [2:0] od, input logic [6:0] m, input logic [2:0] id,
                                       input logic ic, input logic [2:0] rg);
    return {5'h0, od, 1'b0, m, 5'h0, id, ic, 4'h0, rg};
  endfunction

  task automatic check_fields(input logic [31:0] v);
    logic [2:0] c;
    logic [5:0] ratio;
    c = v[26:24];
    ratio = (c >= 3'h1 && c <= 3'h5) ? 6'(1 << c) : 6'h0;
    cmp_word(pack(O_OUTPUT_DIVIDER_FIELD, O_MULTIPLIER_FIELD, O_INPUT_DIVIDER_FIELD,
                  O_INPUT_CLOCK_SELECT, O_INPUT_RANGE_FIELD), v, "fields");
    cmp_word({24'h0, O_MULTIPLY_FACTOR}, {24'h0, 8'(v[22:16]) + 8'h1}, "factor");
    cmp_word({25'h0, O_OUTPUT_DIVIDER_LEGAL, O_OUTPUT_DIVIDE_RATIO}, {25'h0, ratio != 6'h0, ratio}, "ratio");
  endtask

  initial begin
    repeat (5000) @(posedge I_CORE_CLK);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    logic [31:0] e;
    int i;
    I_RST_N = 1'b0;
    I_AWVALID = 1'b0;
    I_WVALID = 1'b0;
    I_ARVALID = 1'b0;
    I_AWADDR = 32'h0;
    I_WDATA = 32'h0;
    I_ARADDR = 32'h0;
    I_WSTRB = 4'h0;
    // Responses are always accepted at once
    I_BREADY = 1'b1;
    I_RREADY = 1'b1;
    I_CFG_OUTPUT_DIVIDER_DEFAULT = 3'h3;
    I_CFG_MULTIPLIER_DEFAULT = 7'h31;
    I_CFG_INPUT_DIVIDER_DEFAULT = 3'h5;
    I_CFG_INPUT_CLOCK_SELECT_DEFAULT = 1'b1;
    I_CFG_INPUT_RANGE_DEFAULT = 3'h6;
    I_CURRENT_OSCILLATOR_CODE = 3'h0;
    repeat (20) @(posedge I_CORE_CLK);
    I_RST_N <= 1'b1;
    @(posedge I_CORE_CLK);
    e = pack(3'h3, 7'h31, 3'h5, 1'b1, 3'h6);
    chk_read(`ADDR_PLL_CONTROL, e, `RESP_OKAY);
    check_fields(e);
    wr(`ADDR_PLL_CONTROL, 32'h0, 4'hf, `RESP_OKAY);
    chk_read(`ADDR_PLL_CONTROL, e, `RESP_OKAY);
    chk_read(`ADDR_STATUS, 32'h4, `RESP_OKAY);
    wr(`ADDR_STATUS, 32'h4, 4'h1, `RESP_OKAY);
    chk_read(`ADDR_STATUS, 32'h0, `RESP_OKAY);
    unlock();
    chk_read(`ADDR_STATUS, 32'h1, `RESP_OKAY);
    wr(`ADDR_PLL_CONTROL, 32'hffff_ffff, 4'hf, `RESP_OKAY);
    e = 32'h077f_0787;
    chk_read(`ADDR_PLL_CONTROL, e, `RESP_OKAY);
    check_fields(e);
    // An accepted write spends the unlock
    wr(`ADDR_PLL_CONTROL, 32'h0, 4'hf, `RESP_OKAY);
    chk_read(`ADDR_PLL_CONTROL, e, `RESP_OKAY);
    // A foreign write between the keys breaks the sequence
    wr(`ADDR_UNLOCK_KEY, `UNLOCK_KEY_FIRST, 4'hf, `RESP_OKAY);
    wr(`ADDR_STATUS, 32'h4, 4'h1, `RESP_OKAY);
    wr(`ADDR_UNLOCK_KEY, `UNLOCK_KEY_SECOND, 4'hf, `RESP_OKAY);
    wr(`ADDR_PLL_CONTROL, 32'h0, 4'hf, `RESP_OKAY);
    chk_read(`ADDR_PLL_CONTROL, e, `RESP_OKAY);
    wr(`ADDR_STATUS, 32'h4, 4'h1, `RESP_OKAY);
    unlock();
    wr(`ADDR_PLL_CONTROL, 32'h0, 4'h4, `RESP_OKAY);
    e = 32'h0700_0787;
    chk_read(`ADDR_PLL_CONTROL, e, `RESP_OKAY);
    check_fields(e);
    for (i = 0; i < 8; i++) begin
      unlock();
      e = pack(i[2:0], 7'(i * 17), 3'(7 - i), i[0], 3'(i + 2));
      wr(`ADDR_PLL_CONTROL, e | 32'hf800_f878, 4'hf, `RESP_OKAY);
      chk_read(`ADDR_PLL_CONTROL, e, `RESP_OKAY);
      check_fields(e);
    end
    I_CURRENT_OSCILLATOR_CODE <= `CURRENT_OSCILLATOR_CODE_LOOP_ACTIVE;
    @(posedge I_CORE_CLK);
    unlock();
    wr(`ADDR_PLL_CONTROL, 32'h0, 4'hf, `RESP_OKAY);
    chk_read(`ADDR_PLL_CONTROL, e, `RESP_OKAY);
    chk_read(`ADDR_STATUS, 32'h6, `RESP_OKAY);
    I_CURRENT_OSCILLATOR_CODE <= 3'h2;
    @(posedge I_CORE_CLK);
    unlock();
    e = pack(3'h5, 7'h7f, 3'h0, 1'b0, 3'h1);
    wr(`ADDR_PLL_CONTROL, e, 4'hf, `RESP_OKAY);
    chk_read(`ADDR_PLL_CONTROL, e, `RESP_OKAY);
    check_fields(e);
    wr(4'hc, 32'hffff_ffff, 4'hf, `RESP_SLVERR);
    chk_read(4'hc, 32'h0, `RESP_SLVERR);
    chk_read(`ADDR_PLL_CONTROL, e, `RESP_OKAY);
    // Second reset with other configuration levels, taken while unlocked
    unlock();
    I_CFG_OUTPUT_DIVIDER_DEFAULT <= 3'h1;
    I_CFG_MULTIPLIER_DEFAULT <= 7'h00;
    I_CFG_INPUT_DIVIDER_DEFAULT <= 3'h2;
    I_CFG_INPUT_CLOCK_SELECT_DEFAULT <= 1'b0;
    I_CFG_INPUT_RANGE_DEFAULT <= 3'h3;
    I_RST_N <= 1'b0;
    repeat (3) @(posedge I_CORE_CLK);
    I_RST_N <= 1'b1;
    @(posedge I_CORE_CLK);
    e = pack(3'h1, 7'h00, 3'h2, 1'b0, 3'h3);
    chk_read(`ADDR_PLL_CONTROL, e, `RESP_OKAY);
    check_fields(e);
    wr(`ADDR_PLL_CONTROL, 32'hffff_ffff, 4'hf, `RESP_OKAY);
    chk_read(`ADDR_PLL_CONTROL, e, `RESP_OKAY);
    chk_read(`ADDR_STATUS, 32'h4, `RESP_OKAY);
    report_and_stop();
  end
endmodule // system_pll_control_bench
`default_nettype wire
